// ### ccz_ctl0.v
// control register zero of a can protocol controller with timestamp and events
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ccz_defs.vh"
// Notes on behaviour
// [RULE_01] set received-frame flag on every valid received message, filters ignored
// [RULE_02] writing 1 clears the received-frame flag; 0 does nothing
// [RULE_03] the flag stays set until cleared by software or reset
// [RULE_04] received-frame and receiver-active are meaningless in loopback
// [RULE_05] receiver-active is read-only, from receiver front end
// [RULE_06] wait-stop bit gates bus interface clocks during cpu wait mode
// [RULE_07] synchronised bit is read-only, maintained by the controller
// [RULE_08] timer enable runs a 16-bit counter at bit clock rate
// [RULE_09] timestamp goes to buffer bytes 0x0e and 0x0f after end of frame
// [RULE_10] disabled timer is held at zero
// [RULE_11] timer enable is forced low during initialisation mode
// [RULE_12] register held in reset in init mode except wakeup, sleep, init request
// [RULE_13] register writable again once request and acknowledge are both zero
// [RULE_14] writes only outside init mode; init request always writable; the code also writes wake-up enable and sleep request in init mode
// [RULE_15] reads allowed anytime, sampled on the internal clock
// [RULE_16] init request aborts transfers and sets init acknowledge
// [RULE_17] sleep granted only when bus idle, no reception, transmit buffers empty
// [RULE_18] received-frame flag also raises a maskable event
module ccz_ctl0 #(
    parameter TS_W = 16
) (
    // clock and reset
    input wire clock,
    input wire rstn,
    // register port
    input wire [`CCZ_AW-1:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata_q,
    // protocol engine status, same clock
    input wire frame_ok,
    input wire rx_front_active,
    input wire bus_synced,
    input wire bus_idle,
    input wire tx_empty,
    input wire bit_tick,
    input wire eof_tick,
    input wire loopback,
    // cpu wait mode from another domain
    input wire cpu_wait,
    // protocol engine control
    output reg abort_q,
    output reg init_ack_q,
    output reg sleep_ack_q,
    output reg bus_clk_gate_q,
    // timestamp write into active buffer
    output reg ts_we_q,
    output reg [3:0] ts_addr_q,
    output reg [7:0] ts_data_q,
    // interrupt
    output reg irq_q
);
    // control register bits
    reg rx_frame_q;
    reg wait_stop_q;
    reg time_q;
    reg wakeup_en_q;
    reg sleep_req_q;
    reg init_req_q;
    // event status and mask
    reg [`CCZ_NEV-1:0] stat_q;
    reg [`CCZ_NEV-1:0] mask_q;
    // timestamp staging
    reg [7:0] ts_hi_q;
    reg ts_pend_q;
    // edge history
    reg synced_prev_q;
    reg init_ack_prev_q;
    reg sleep_ack_prev_q;
    // decode and muxes
    wire [TS_W-1:0] ts_count;
    wire wait_s;
    wire init_mode;
    wire ctl_open;
    wire wr_ctl0;
    wire rd_stat;
    wire [`CCZ_NEV-1:0] stat_d;
    reg [7:0] ctl0_view;
    reg [7:0] rdata_d;
    reg [`CCZ_NEV-1:0] ev;

    function sel;
        input [`CCZ_AW-1:0] a;
        input [`CCZ_AW-1:0] b;
        input s;
        begin
            sel = s && (a == b);
        end
    endfunction

    // widen an event vector to a byte for the read port
    function [7:0] pad_ev;
        input [`CCZ_NEV-1:0] e;
        begin
            pad_ev = {{(8-`CCZ_NEV){1'b0}}, e};
        end
    endfunction

    // init mode needs both halves of the handshake; writes reopen only when both are low
    assign init_mode = init_req_q && init_ack_q;
    assign ctl_open = !init_req_q && !init_ack_q; // [RULE_13]
    // next status: a read clears, but a new event in the same cycle still lands
    assign stat_d = (rd_stat ? {`CCZ_NEV{1'b0}} : stat_q) | ev;
    assign wr_ctl0 = sel(addr, `CCZ_ADDR_CTL0, wr);
    assign rd_stat = sel(addr, `CCZ_ADDR_STAT, rd);

    ccz_sync #(.W(1)) u_wait_sync (
        .clock(clock),
        .rstn(rstn),
        .d(cpu_wait),
        .q(wait_s)
    );

    ccz_timer #(.W(TS_W)) u_timer (
        .clock(clock),
        .rstn(rstn),
        .enable(time_q),
        .bit_tick(bit_tick),
        .count_q(ts_count)
    );

    // received-frame flag: a hardware set wins over a same-cycle write-1 clear
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rx_frame_q <= 1'b0;
        end else if (init_mode) begin
            rx_frame_q <= 1'b0; // [RULE_12]
        end else if (frame_ok) begin
            rx_frame_q <= 1'b1; // [RULE_01] [RULE_03]
        end else if (wr_ctl0 && wdata[`CCZ_BIT_RX_FRAME]) begin
            rx_frame_q <= 1'b0; // [RULE_02]
        end
    end

    // wait-stop bit: held clear in init, writable only once init is fully left
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wait_stop_q <= 1'b0;
        end else if (init_mode) begin
            wait_stop_q <= 1'b0; // [RULE_12]
        end else if (wr_ctl0 && ctl_open) begin
            wait_stop_q <= wdata[`CCZ_BIT_WAIT_STOP]; // [RULE_14]
        end
    end

    // timer enable: forced low through init mode, which also clears the count
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            time_q <= 1'b0;
        end else if (init_mode) begin
            time_q <= 1'b0; // [RULE_11]
        end else if (wr_ctl0 && ctl_open) begin
            time_q <= wdata[`CCZ_BIT_TIME]; // [RULE_13] [RULE_14]
        end
    end

    // wake-up enable survives init mode
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wakeup_en_q <= 1'b0;
        end else if (wr_ctl0) begin
            wakeup_en_q <= wdata[`CCZ_BIT_WAKEUP]; // [RULE_12]
        end
    end

    // sleep request: the cpu may not withdraw it before sleep is acknowledged
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sleep_req_q <= 1'b0;
        end else if (wr_ctl0 && (wdata[`CCZ_BIT_SLEEP_REQ] || sleep_ack_q || !sleep_req_q)) begin
            sleep_req_q <= wdata[`CCZ_BIT_SLEEP_REQ];
        end
    end

    // init request: writable in init mode, but cannot be dropped before its acknowledge
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            init_req_q <= 1'b1;
        end else if (wr_ctl0 && (wdata[`CCZ_BIT_INIT_REQ] || init_ack_q || !init_req_q)) begin
            init_req_q <= wdata[`CCZ_BIT_INIT_REQ]; // [RULE_14]
        end
    end

    // abort pulse while init is requested but not yet acknowledged
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= init_req_q && !init_ack_q; // [RULE_16]
        end
    end

    // acknowledge follows the request one cycle later; the engine winds down on the abort
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            init_ack_q <= 1'b0;
        end else begin
            init_ack_q <= init_req_q; // [RULE_16]
        end
    end

    // sleep is granted only on an idle bus and dropped as soon as the request goes
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sleep_ack_q <= 1'b0;
        end else if (!sleep_req_q) begin
            sleep_ack_q <= 1'b0;
        end else if (bus_idle && !rx_front_active && tx_empty) begin
            sleep_ack_q <= 1'b1; // [RULE_17]
        end
    end

    // bus interface clock gate: stops only during wait with the bit set
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bus_clk_gate_q <= 1'b0;
        end else begin
            bus_clk_gate_q <= wait_stop_q && wait_s; // [RULE_06]
        end
    end

    // timestamp: low byte then high byte one cycle later, high byte latched
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ts_we_q <= 1'b0;
            ts_addr_q <= 4'h0;
            ts_data_q <= 8'h00;
            ts_hi_q <= 8'h00;
            ts_pend_q <= 1'b0;
        end else begin
            ts_we_q <= 1'b0;
            ts_pend_q <= 1'b0;
            if (time_q && eof_tick) begin
                ts_we_q <= 1'b1; // [RULE_09]
                ts_addr_q <= `CCZ_TS_LO_BYTE;
                ts_data_q <= ts_count[7:0];
                ts_hi_q <= ts_count[15:8];
                ts_pend_q <= 1'b1;
            end else if (ts_pend_q) begin
                ts_we_q <= 1'b1; // [RULE_09]
                ts_addr_q <= `CCZ_TS_HI_BYTE;
                ts_data_q <= ts_hi_q;
            end
        end
    end

    // events: each valid frame outside init mode plus rising edges of synced and both acknowledges, sticky until the status register is read
    always @* begin
        ev = {`CCZ_NEV{1'b0}};
        ev[`CCZ_EV_RX_FRAME] = frame_ok && !init_mode; // [RULE_18]
        ev[`CCZ_EV_SYNCED] = bus_synced && !synced_prev_q;
        ev[`CCZ_EV_INIT_ACK] = init_ack_q && !init_ack_prev_q;
        ev[`CCZ_EV_SLEEP_ACK] = sleep_ack_q && !sleep_ack_prev_q;
    end

    // edge history; all three sources idle low, so no false edge follows reset
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            synced_prev_q <= 1'b0;
            init_ack_prev_q <= 1'b0;
            sleep_ack_prev_q <= 1'b0;
        end else begin
            synced_prev_q <= bus_synced;
            init_ack_prev_q <= init_ack_q;
            sleep_ack_prev_q <= sleep_ack_q;
        end
    end

    // status: a new event beats the clear of a same-cycle read
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stat_q <= {`CCZ_NEV{1'b0}};
        end else begin
            stat_q <= stat_d; // [RULE_18]
        end
    end

    // mask register
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mask_q <= {`CCZ_NEV{1'b0}};
        end else if (sel(addr, `CCZ_ADDR_MASK, wr)) begin
            mask_q <= wdata[`CCZ_NEV-1:0];
        end
    end

    // level interrupt, taken from the next status so it drops with the clearing read
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_d & mask_q); // [RULE_18]
        end
    end

    // loopback leaves the flag meaningless; software must ignore it there
    // read-only status bits come straight from the engine, gated by init mode
    always @* begin
        ctl0_view = 8'h00;
        ctl0_view[`CCZ_BIT_RX_FRAME] = rx_frame_q; // [RULE_04]
        ctl0_view[`CCZ_BIT_RX_ACTIVE] = rx_front_active && !init_mode && !loopback; // [RULE_04] [RULE_05]
        ctl0_view[`CCZ_BIT_WAIT_STOP] = wait_stop_q;
        ctl0_view[`CCZ_BIT_SYNCED] = bus_synced && !init_mode; // [RULE_07]
        ctl0_view[`CCZ_BIT_TIME] = time_q;
        ctl0_view[`CCZ_BIT_WAKEUP] = wakeup_en_q;
        ctl0_view[`CCZ_BIT_SLEEP_REQ] = sleep_req_q;
        ctl0_view[`CCZ_BIT_INIT_REQ] = init_req_q;
    end

    // read mux; an idle cycle gives zero so the answer stands for one cycle only
    always @* begin
        rdata_d = 8'h00;
        if (rd) begin
            case (addr)
                `CCZ_ADDR_CTL0: rdata_d = ctl0_view;
                `CCZ_ADDR_CTL1: rdata_d = {6'h00, sleep_ack_q, init_ack_q};
                `CCZ_ADDR_STAT: rdata_d = pad_ev(stat_q);
                `CCZ_ADDR_MASK: rdata_d = pad_ev(mask_q);
                `CCZ_ADDR_TSLO: rdata_d = ts_count[7:0];
                `CCZ_ADDR_TSHI: rdata_d = ts_count[15:8];
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // read data registered one cycle after the strobe, on the same clock as every bit
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d; // [RULE_15]
        end
    end
endmodule
`default_nettype wire

// ### ccz_defs.vh
// constants for the can control register zero block
`ifndef CCZ_DEFS_VH
`define CCZ_DEFS_VH
`define CCZ_AW 3
`define CCZ_ADDR_CTL0 3'h0
`define CCZ_ADDR_CTL1 3'h1
`define CCZ_ADDR_STAT 3'h2
`define CCZ_ADDR_MASK 3'h3
`define CCZ_ADDR_TSLO 3'h4
`define CCZ_ADDR_TSHI 3'h5
`define CCZ_BIT_RX_FRAME 7
`define CCZ_BIT_RX_ACTIVE 6
`define CCZ_BIT_WAIT_STOP 5
`define CCZ_BIT_SYNCED 4
`define CCZ_BIT_TIME 3
`define CCZ_BIT_WAKEUP 2
`define CCZ_BIT_SLEEP_REQ 1
`define CCZ_BIT_INIT_REQ 0
`define CCZ_CTL0_RESET 8'h01
`define CCZ_TS_LO_BYTE 4'he
`define CCZ_TS_HI_BYTE 4'hf
`define CCZ_EV_RX_FRAME 0
`define CCZ_EV_SYNCED 1
`define CCZ_EV_INIT_ACK 2
`define CCZ_EV_SLEEP_ACK 3
`define CCZ_NEV 4
`endif

// ### ccz_sync.v
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module ccz_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clock,
    input wire rstn,
    // data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_q;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_q <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### ccz_timer.v
// free-running timestamp counter ticked by the bit clock enable
`timescale 1ns/1ps
`default_nettype none
module ccz_timer #(
    parameter W = 16
) (
    // clock and reset
    input wire clock,
    input wire rstn,
    // control
    input wire enable,
    input wire bit_tick,
    // count
    output reg [W-1:0] count_q
);
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_q <= {W{1'b0}};
        end else if (!enable) begin
            count_q <= {W{1'b0}}; // [RULE_10]
        end else if (bit_tick) begin
            count_q <= count_q + {{(W-1){1'b0}}, 1'b1}; // [RULE_08]
        end
    end
endmodule
`default_nettype wire

// ### ccz_ctl0_assertions.sv
// port assertions for control register zero
`timescale 1ns/1ps
`default_nettype none
module ccz_ctl0_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata_q,
    // engine side and outputs
    input wire logic frame_ok,
    input wire logic eof_tick,
    input wire logic loopback,
    input wire logic abort_q,
    input wire logic init_ack_q,
    input wire logic ts_we_q,
    input wire logic [3:0] ts_addr_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // flag reads only mean something outside init and loopback
    sequence ctl_rd_s;
        rd && addr == 3'h0 && !init_ack_q && !loopback;
    endsequence
    sequence clr_s;
        wr && addr == 3'h0 && wdata[7] && !frame_ok;
    endsequence
    rd_idle_zero_a: assert property (!$past(rd) |-> rdata_q == 8'h00)
        else $error("read data outside answer");
    ts_pair_a: assert property (ts_we_q && ts_addr_q == 4'he |=> ts_we_q && ts_addr_q == 4'hf)
        else $error("stamp high byte missing");
    ts_after_eof_a: assert property (ts_we_q && ts_addr_q == 4'he |-> $past(eof_tick))
        else $error("stamp without frame end");
    init_leave_a: assert property (wr && addr == 3'h0 && !wdata[0] && init_ack_q |-> ##[1:2] !init_ack_q)
        else $error("init not left");
    init_enter_a: assert property (wr && addr == 3'h0 && wdata[0] && !init_ack_q |-> ##[1:2] init_ack_q)
        else $error("init not entered");
    abort_short_a: assert property (abort_q |-> ##[1:2] !abort_q)
        else $error("abort stuck");
    init_held_a: assert property (rd && addr == 3'h0 && init_ack_q && $past(init_ack_q) |=> rdata_q[7:3] == 5'h00)
        else $error("bits not held in init");
    rx_frame_set_a: assert property (frame_ok && !init_ack_q && !loopback ##1 ctl_rd_s |=> rdata_q[7])
        else $error("frame flag not set");
    rx_frame_clr_a: assert property (clr_s ##1 !frame_ok ##1 ctl_rd_s |=> !rdata_q[7])
        else $error("frame flag not cleared");
endmodule
bind ccz_ctl0 ccz_ctl0_chk i_chk (.*);
`default_nettype wire

// ### ccz_can_model.sv
// far-side protocol engine model: bit ticks and received frames
`timescale 1ns/1ps
`default_nettype none
module ccz_can_model (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // frame command: start pulse and length in bits
    input wire logic go,
    input wire logic [5:0] nbits,
    // engine status
    output logic frame_ok,
    output logic rx_front_active,
    output logic bus_synced,
    output logic bus_idle,
    output logic tx_empty,
    output logic bit_tick,
    output logic eof_tick
);
    logic [1:0] div_q;
    logic [5:0] left_q;
    assign rx_front_active = left_q != 6'h00;
    assign bus_idle = !rx_front_active;
    assign tx_empty = 1'b1;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_q <= 2'h0;
            left_q <= 6'h00;
            {frame_ok, eof_tick, bit_tick, bus_synced} <= 4'h0;
        end else begin
            div_q <= div_q + 2'h1;
            bit_tick <= div_q == 2'h3;
            frame_ok <= 1'b0;
            eof_tick <= 1'b0;
            if (bit_tick) bus_synced <= 1'b1;
            if (go) begin
                left_q <= nbits;
            end else if (bit_tick && left_q != 6'h00) begin
                left_q <= left_q - 6'h01;
                // frame end and validity come together, as seen by the receiver
                frame_ok <= left_q == 6'h01;
                eof_tick <= left_q == 6'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for control register zero
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock, rstn, wr, rd, go, loopback, cpu_wait;
    logic [2:0] addr;
    logic [7:0] wdata, rdata_q, v;
    logic [5:0] nbits;
    logic frame_ok, rx_front_active, bus_synced, bus_idle, tx_empty, bit_tick, eof_tick;
    logic init_ack_q, irq_q, bus_clk_gate_q, ts_we_q;
    logic [3:0] ts_addr_q;
    logic [7:0] ts_data_q;
    logic [15:0] ts_last, ts_prev;
    int n_mismatch, n_checks, n_ts, cyc, k, i;
    integer seed;
    always #10 clock = ~clock;
    ccz_can_model m (.*);
    ccz_ctl0 i_dut (.*, .abort_q(), .sleep_ack_q());
    function automatic logic [7:0] exp_ctl(logic [7:0] w, logic init, logic rxf, logic syn);
        return init ? {5'h00, w[2:1], 1'b1} : {rxf, 1'b0, w[5], syn, w[3:0]};
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrr(logic [2:0] a, logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rdr(logic [2:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 v = rdata_q;
    endtask
    task automatic rc(logic [2:0] a, logic [7:0] exp);
        rdr(a);
        chk(v, exp);
    endtask
    task automatic frame(logic [5:0] n);
        @(posedge clock);
        go <= 1'b1;
        nbits <= n;
        @(posedge clock);
        go <= 1'b0;
    endtask
    // bounded wait so a lost frame cannot hang the run
    task automatic wait_frame();
        k = 0;
        while (frame_ok !== 1'b1 && k < 500) begin
            @(posedge clock);
            #1 k++;
        end
        chk({7'h0, frame_ok}, 8'h01);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (ts_we_q === 1'b1 && ts_addr_q === 4'he) ts_last[7:0] = ts_data_q;
        if (ts_we_q === 1'b1 && ts_addr_q === 4'hf) ts_last[15:8] = ts_data_q;
        if (ts_we_q === 1'b1 && ts_addr_q === 4'hf) n_ts++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        seed = 32'h3e9920d2;
        {clock, rstn, wr, rd, go, loopback, cpu_wait} = 7'h00;
        {addr, wdata, nbits} = 17'h00000;
        ts_last = 16'h0000;
        ts_prev = 16'h0000;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        rc(3'h0, 8'h01);
        rc(3'h1, 8'h01);
        wrr(3'h0, 8'hfd);
        rc(3'h0, exp_ctl(8'hfd, 1, 0, 0));
        wrr(3'h0, 8'h00);
        repeat (3) @(posedge clock);
        rc(3'h1, 8'h00);
        wrr(3'h0, 8'h28);
        rc(3'h0, exp_ctl(8'h28, 0, 0, 1));
        rdr(3'h2);
        wrr(3'h3, 8'h01);
        $display("test init done");
        for (i = 0; i < 4; i++) begin
            ts_prev = ts_last;
            frame(6'd4 + 6'($random(seed) & 7));
            wait_frame();
            rc(3'h0, exp_ctl(8'h28, 0, 1, 1));
            chk({7'h0, irq_q}, 8'h01);
            rc(3'h2, 8'h01);
            @(posedge clock);
            #1 chk({7'h0, irq_q}, 8'h00);
            wrr(3'h0, 8'h28);
            rc(3'h0, exp_ctl(8'h28, 0, 1, 1));
            wrr(3'h0, 8'ha8);
            rc(3'h0, exp_ctl(8'h28, 0, 0, 1));
            chk(8'(n_ts), 8'(i + 1));
            chk({7'h0, ts_last > ts_prev}, 8'h01);
        end
        $display("test frames done");
        wrr(3'h6 | 3'($random(seed) & 1), 8'($random(seed)));
        rc(3'h7, 8'h00);
        rdr(3'h4);
        chk({7'h0, |v}, 8'h01);
        wrr(3'h0, 8'h20);
        rc(3'h4, 8'h00);
        rc(3'h5, 8'h00);
        cpu_wait <= 1'b1;
        repeat (4) @(posedge clock);
        #1 chk({7'h0, bus_clk_gate_q}, 8'h01);
        wrr(3'h0, 8'h00);
        repeat (3) @(posedge clock);
        #1 chk({7'h0, bus_clk_gate_q}, 8'h00);
        @(posedge clock);
        cpu_wait <= 1'b0;
        $display("test timer and wait done");
        frame(6'd10);
        wrr(3'h0, 8'h02);
        rc(3'h1, 8'h00);
        wait_frame();
        repeat (3) @(posedge clock);
        rc(3'h1, 8'h02);
        wrr(3'h0, 8'h00);
        repeat (3) @(posedge clock);
        wrr(3'h0, 8'h09);
        repeat (3) @(posedge clock);
        rc(3'h1, 8'h01);
        rc(3'h0, 8'h01);
        $display("test sleep and init done");
        final_report();
    end
endmodule
`default_nettype wire
